// File: shared/pmc_pkg.sv
// Package of constants for the power mode controller
package pmc_pkg;
	// Register byte addresses on APB
	localparam logic [11:0] ADDR_POWER_MODE_CONTROL = 12'h000;
	localparam logic [11:0] ADDR_REGULATOR_CONTROL = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	// Field positions in power_mode_control
	localparam int IDLE_BIT = 0;
	localparam int STOP_BIT = 1;
	localparam int FLAGS_LSB = 2;
	localparam int FLAGS_MSB = 7;
	// Field position in regulator_control
	localparam int SHUTDOWN_BIT = 3;
	// Reset values
	localparam logic [5:0] FLAGS_RESET = 6'h00;
	localparam logic SHUTDOWN_RESET = 1'b0;
	// Program restart address after a reset
	localparam logic [15:0] RESTART_ADDR = 16'h0000;
	// Status register bit positions
	localparam int ST_IDLE_BIT = 0;
	localparam int ST_STOP_BIT = 1;
	localparam int ST_REG_OFF_BIT = 2;
	// Cycles from write completion to mode entry
	localparam int ENTRY_DELAY_CYCLES = 1;
	typedef enum logic [1:0] {
		PMC_RUN,
		PMC_IDLE,
		PMC_STOP
	} pmc_mode_e;
endpackage

// File: logic/pmc_sync.sv
// Two flip-flop synchroniser for asynchronous wake and reset sources
`timescale 1ns/10ps
module pmc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	// Refuse an empty synchroniser
	if (WIDTH < 1) begin : g_bad_width
		$error("pmc_sync needs WIDTH of at least 1");
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1 <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule

// File: logic/pmc_apb.sv
// APB slave decode for the power mode controller registers
`timescale 1ns/10ps
module pmc_apb (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [7:0] pmc_reg,
	input wire logic [7:0] reg_ctl,
	input wire logic [7:0] status,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	output logic wr_pmc,
	output logic wr_reg,
	output logic [7:0] wdata
);
	logic access;
	logic hit;

	assign access = psel && penable && !pready;
	assign hit = (paddr == pmc_pkg::ADDR_POWER_MODE_CONTROL) ||
		(paddr == pmc_pkg::ADDR_REGULATOR_CONTROL) ||
		(paddr == pmc_pkg::ADDR_STATUS);

	// Answer one cycle into the access phase, from flops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= access;
			pslverr <= access && !hit;
			prdata <= 32'h0000_0000;
			if (access && !pwrite) begin
				case (paddr)
				pmc_pkg::ADDR_POWER_MODE_CONTROL: prdata <= {24'h000000, pmc_reg};
				pmc_pkg::ADDR_REGULATOR_CONTROL: prdata <= {24'h000000, reg_ctl};
				pmc_pkg::ADDR_STATUS: prdata <= {24'h000000, status};
				default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Write strobes land at the edge that completes the access
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_pmc <= 1'b0;
			wr_reg <= 1'b0;
			wdata <= 8'h00;
		end else begin
			wr_pmc <= access && pwrite &&
				(paddr == pmc_pkg::ADDR_POWER_MODE_CONTROL);
			wr_reg <= access && pwrite &&
				(paddr == pmc_pkg::ADDR_REGULATOR_CONTROL);
			wdata <= pwdata[7:0];
		end
	end
endmodule

// File: logic/pmc_top.sv
// Power mode controller: idle and stop modes with regulator shutdown
//
// Behaviour
// - Writing idle bit halts CPU and enters idle after the write completes.
// - Idle keeps registers, memory, clocks and peripherals running.
// - Idle ends on reset or enabled interrupt; interrupt clears idle.
// - Interrupt wake services interrupt, then resumes the next instruction.
// - Reset ending idle or stop restarts fetch at address zero.
// - Enabled watchdog keeps running in idle and its reset ends idle.
// - Writing stop bit enters stop after the write completes.
// - Stop halts oscillator, CPU, digital peripherals, timers, interrupts.
// - Stop ends only on reset; interrupts never wake it.
// - Enabled missing clock detector resets out of stop.
// - Regulator stays on in stop by default; any reset source works.
// - Shutdown bit set powers regulator off in stop; only pin or power cycle reset.
// - Bits 7 to 2 are plain read-write general flags.
// - Stop and idle bits always read as zero.
// - Shutdown bit is bit 3 of regulator control, reset to zero.
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/10ps
module pmc_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	input wire logic irq_pending,
	input wire logic watchdog_timer_expired,
	input wire logic watchdog_timer_enabled,
	input wire logic missing_clock_detector_fault,
	input wire logic missing_clock_detector_enabled,
	input wire logic reset_pin_n,
	output logic cpu_halt,
	output logic cpu_resume,
	output logic internal_osc_enable,
	output logic digital_clock_enable,
	output logic interrupts_enable,
	output logic regulator_enable,
	output logic internal_reset,
	output logic [15:0] restart_addr,
	output logic [1:0] mode_state
);
	logic [7:0] pmc_reg;
	logic [7:0] reg_ctl;
	logic [7:0] status;
	logic wr_pmc;
	logic wr_reg;
	logic [7:0] wdata;
	logic [5:0] general_purpose_flags;
	logic regulator_stop_shutdown;
	logic [3:0] sync_in;
	logic [3:0] sync_out;
	logic irq_s;
	logic wdt_s;
	logic mcd_s;
	logic pin_rst_s;
	logic idle_req;
	logic stop_req;
	logic reset_event;
	pmc_pkg::pmc_mode_e mode;
	pmc_pkg::pmc_mode_e next_mode;

	pmc_apb u_apb (
		.clk(clk),
		.rst(rst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pmc_reg(pmc_reg),
		.reg_ctl(reg_ctl),
		.status(status),
		.pready(pready),
		.pslverr(pslverr),
		.prdata(prdata),
		.wr_pmc(wr_pmc),
		.wr_reg(wr_reg),
		.wdata(wdata)
	);

	assign sync_in = {!reset_pin_n, missing_clock_detector_fault,
		watchdog_timer_expired, irq_pending};

	pmc_sync #(.WIDTH(4)) u_sync (
		.clk(clk),
		.rst(rst),
		.async_in(sync_in),
		.sync_out(sync_out)
	);

	assign irq_s = sync_out[0];
	assign wdt_s = sync_out[1] && watchdog_timer_enabled;
	assign mcd_s = sync_out[2] && missing_clock_detector_enabled;
	assign pin_rst_s = sync_out[3];

	always_comb begin
		pmc_reg = 8'h00;
		pmc_reg[pmc_pkg::FLAGS_MSB:pmc_pkg::FLAGS_LSB] =
			general_purpose_flags;
	end

	// Shutdown bit at its package position
	always_comb begin
		reg_ctl = 8'h00;
		reg_ctl[pmc_pkg::SHUTDOWN_BIT] = regulator_stop_shutdown;
	end

	// Status bits at their package positions
	always_comb begin
		status = 8'h00;
		status[pmc_pkg::ST_IDLE_BIT] = mode == pmc_pkg::PMC_IDLE;
		status[pmc_pkg::ST_STOP_BIT] = mode == pmc_pkg::PMC_STOP;
		status[pmc_pkg::ST_REG_OFF_BIT] =
			(mode == pmc_pkg::PMC_STOP) && regulator_stop_shutdown;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			general_purpose_flags <= pmc_pkg::FLAGS_RESET;
		end else if (wr_pmc) begin
			general_purpose_flags <=
				wdata[pmc_pkg::FLAGS_MSB:pmc_pkg::FLAGS_LSB];
		end
	end

	// shutdown bit at bit 3, reset zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			regulator_stop_shutdown <= pmc_pkg::SHUTDOWN_RESET;
		end else if (wr_reg) begin
			regulator_stop_shutdown <= wdata[pmc_pkg::SHUTDOWN_BIT];
		end
	end

	assign stop_req = wr_pmc && wdata[pmc_pkg::STOP_BIT];
	assign idle_req = wr_pmc && wdata[pmc_pkg::IDLE_BIT] && !stop_req;

	// with regulator off only the pin resets
	// regulator on, any enabled source resets
	always_comb begin
		if (mode == pmc_pkg::PMC_STOP && regulator_stop_shutdown) begin
			reset_event = pin_rst_s;
		end else begin
			reset_event = pin_rst_s || wdt_s || mcd_s;
		end
	end

	always_comb begin
		next_mode = mode;
		case (mode)
		pmc_pkg::PMC_RUN: begin
			if (stop_req) begin
				next_mode = pmc_pkg::PMC_STOP;
			end else if (idle_req) begin
				next_mode = pmc_pkg::PMC_IDLE;
			end
		end
		pmc_pkg::PMC_IDLE: begin
			if (reset_event || irq_s) begin
				next_mode = pmc_pkg::PMC_RUN;
			end
		end
		pmc_pkg::PMC_STOP: begin
			if (reset_event) begin
				next_mode = pmc_pkg::PMC_RUN;
			end
		end
		default: next_mode = pmc_pkg::PMC_RUN;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode <= pmc_pkg::PMC_RUN;
		end else begin
			mode <= next_mode;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			internal_reset <= 1'b0;
			restart_addr <= pmc_pkg::RESTART_ADDR;
		end else begin
			internal_reset <= reset_event && mode != pmc_pkg::PMC_RUN;
			restart_addr <= pmc_pkg::RESTART_ADDR;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cpu_resume <= 1'b0;
		end else begin
			cpu_resume <= mode == pmc_pkg::PMC_IDLE && irq_s &&
				!reset_event;
		end
	end

	// stop gates oscillator, logic and interrupts
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cpu_halt <= 1'b0;
			internal_osc_enable <= 1'b1;
			digital_clock_enable <= 1'b1;
			interrupts_enable <= 1'b1;
			regulator_enable <= 1'b1;
			mode_state <= 2'h0;
		end else begin
			cpu_halt <= next_mode != pmc_pkg::PMC_RUN;
			internal_osc_enable <= next_mode != pmc_pkg::PMC_STOP;
			digital_clock_enable <= next_mode != pmc_pkg::PMC_STOP;
			interrupts_enable <= next_mode != pmc_pkg::PMC_STOP;
			regulator_enable <= !(next_mode == pmc_pkg::PMC_STOP &&
				regulator_stop_shutdown);
			mode_state <= next_mode;
		end
	end
endmodule

// File: verif/pmc_checker.sv
// Port assertions for the power mode controller
`timescale 1ns/10ps
module pmc_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic pready,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic irq_pending,
	input wire logic watchdog_timer_expired,
	input wire logic watchdog_timer_enabled,
	input wire logic cpu_halt,
	input wire logic cpu_resume,
	input wire logic internal_osc_enable,
	input wire logic digital_clock_enable,
	input wire logic interrupts_enable,
	input wire logic regulator_enable,
	input wire logic internal_reset,
	input wire logic [1:0] mode_state
);
	logic pm_wr;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	assign pm_wr = pready && pwrite && mode_state == 2'd0
		&& paddr == pmc_pkg::ADDR_POWER_MODE_CONTROL;
	property p_idle;
		pm_wr && pwdata[1:0] == 2'b01 |-> ##[1:3] mode_state == 2'd1;
	endproperty
	a_idle: assert property (p_idle) else $error("no idle");
	property p_stop;
		pm_wr && pwdata[1] |-> ##[1:3] mode_state == 2'd2;
	endproperty
	a_stop: assert property (p_stop) else $error("no stop");
	property p_idle_on;
		mode_state == 2'd1 |-> cpu_halt && internal_osc_enable
			&& digital_clock_enable && interrupts_enable;
	endproperty
	a_idle_on: assert property (p_idle_on) else $error("idle clk");
	property p_stop_off;
		mode_state == 2'd2 |-> cpu_halt && !internal_osc_enable
			&& !interrupts_enable && !digital_clock_enable;
	endproperty
	a_stop_off: assert property (p_stop_off) else $error("stop on");
	property p_no_wake;
		mode_state == 2'd2 |=> mode_state != 2'd1 && !cpu_resume;
	endproperty
	a_no_wake: assert property (p_no_wake) else $error("irq wake");
	property p_irq;
		$rose(irq_pending) && mode_state == 2'd1 |-> ##[1:4] mode_state == 2'd0;
	endproperty
	a_irq: assert property (p_irq) else $error("idle stuck");
	property p_wdt;
		$rose(watchdog_timer_expired) && watchdog_timer_enabled
			&& mode_state == 2'd1 |-> ##[1:4] internal_reset;
	endproperty
	a_wdt: assert property (p_wdt) else $error("no wdt reset");
	property p_reg;
		!regulator_enable |-> mode_state == 2'd2;
	endproperty
	a_reg: assert property (p_reg) else $error("reg off");
	property p_resume;
		cpu_resume |-> mode_state == 2'd0 && $past(mode_state) == 2'd1;
	endproperty
	a_resume: assert property (p_resume) else $error("bad resume");
	property p_rst_exit;
		internal_reset |-> mode_state == 2'd0 && $past(mode_state) != 2'd0;
	endproperty
	a_rst_exit: assert property (p_rst_exit) else $error("bad reset");
endmodule

// File: verif/power_mode_control_test.sv
// Self-checking bench for the power mode controller
`timescale 1ns/10ps
module power_mode_control_test;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, irq_pending = 0, watchdog_timer_expired = 0;
	logic watchdog_timer_enabled = 1, missing_clock_detector_fault = 0;
	logic missing_clock_detector_enabled = 0, reset_pin_n = 1, cpu_halt;
	logic cpu_resume, internal_osc_enable, digital_clock_enable;
	logic interrupts_enable, regulator_enable, internal_reset;
	logic [15:0] restart_addr;
	logic [1:0] mode_state;
	int n_fail = 0, checked = 0;
	localparam logic [11:0] PM = pmc_pkg::ADDR_POWER_MODE_CONTROL;
	localparam logic [11:0] RC = pmc_pkg::ADDR_REGULATOR_CONTROL;
	localparam logic [11:0] ST = pmc_pkg::ADDR_STATUS;
	pmc_top uut (
		.clk(clk),
		.rst(rst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pready(pready),
		.pslverr(pslverr),
		.prdata(prdata),
		.irq_pending(irq_pending),
		.watchdog_timer_expired(watchdog_timer_expired),
		.watchdog_timer_enabled(watchdog_timer_enabled),
		.missing_clock_detector_fault(missing_clock_detector_fault),
		.missing_clock_detector_enabled(missing_clock_detector_enabled),
		.reset_pin_n(reset_pin_n),
		.cpu_halt(cpu_halt),
		.cpu_resume(cpu_resume),
		.internal_osc_enable(internal_osc_enable),
		.digital_clock_enable(digital_clock_enable),
		.interrupts_enable(interrupts_enable),
		.regulator_enable(regulator_enable),
		.internal_reset(internal_reset),
		.restart_addr(restart_addr),
		.mode_state(mode_state)
	);
	initial forever #2 clk = ~clk;
	task automatic check(input logic [31:0] got, exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wait_mode(input logic [1:0] m);
		repeat (12) if (mode_state !== m) @(posedge clk);
		check(mode_state, m);
	endtask
	task automatic t_regs;
		apb(0, PM, 0);
		check(rd, 32'h0);
		apb(0, RC, 0);
		check(rd, 32'h0);
		apb(1, PM, 32'hfc);
		apb(0, PM, 0);
		check(rd, 32'hfc);
		apb(0, 12'h00c, 0);
		check(err, 1'b1);
		$display("test regs done");
	endtask
	task automatic t_idle;
		apb(1, PM, 32'hfd);
		wait_mode(2'd1);
		check(cpu_halt, 1'b1);
		check(digital_clock_enable, 1'b1);
		check(interrupts_enable, 1'b1);
		apb(0, PM, 0);
		check(rd, 32'hfc);
		apb(0, ST, 0);
		check(rd, 32'h01);
		irq_pending <= 1;
		wait_mode(2'd0);
		check(cpu_resume, 1'b1);
		check(cpu_halt, 1'b0);
		irq_pending <= 0;
		$display("test idle done");
	endtask
	task automatic t_wdt;
		apb(1, PM, 32'h01);
		wait_mode(2'd1);
		watchdog_timer_expired <= 1;
		repeat (12) if (internal_reset !== 1'b1) @(posedge clk);
		check(internal_reset, 1'b1);
		check(cpu_resume, 1'b0);
		check({16'h0000, restart_addr}, 32'h0000_0000);
		wait_mode(2'd0);
		watchdog_timer_expired <= 0;
		$display("test watchdog done");
	endtask
	task automatic t_stop;
		apb(1, PM, 32'h03);
		wait_mode(2'd2);
		check(internal_osc_enable, 1'b0);
		check(digital_clock_enable, 1'b0);
		check(interrupts_enable, 1'b0);
		check(cpu_halt, 1'b1);
		irq_pending <= 1;
		repeat (10) @(posedge clk);
		check(mode_state, 2'd2);
		irq_pending <= 0;
		missing_clock_detector_enabled <= 1;
		missing_clock_detector_fault <= 1;
		wait_mode(2'd0);
		missing_clock_detector_fault <= 0;
		$display("test stop done");
	endtask
	task automatic t_shut;
		apb(1, RC, 32'h08);
		apb(0, RC, 0);
		check(rd, 32'h08);
		apb(1, PM, 32'h02);
		wait_mode(2'd2);
		check(regulator_enable, 1'b0);
		apb(0, ST, 0);
		check(rd, 32'h06);
		missing_clock_detector_fault <= 1;
		repeat (10) @(posedge clk);
		check(mode_state, 2'd2);
		reset_pin_n <= 0;
		wait_mode(2'd0);
		check(internal_reset, 1'b1);
		check(regulator_enable, 1'b1);
		reset_pin_n <= 1;
		missing_clock_detector_fault <= 0;
		$display("test shutdown done");
	endtask
	task automatic wrap_up;
		$display("checks %0d failures %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#20000;
		n_fail++;
		wrap_up;
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		t_regs;
		t_idle;
		t_wdt;
		t_stop;
		t_shut;
		wrap_up;
	end
endmodule
bind pmc_top pmc_checker chk (
	.clk(clk),
	.rst(rst),
	.pready(pready),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.irq_pending(irq_pending),
	.watchdog_timer_expired(watchdog_timer_expired),
	.watchdog_timer_enabled(watchdog_timer_enabled),
	.cpu_halt(cpu_halt),
	.cpu_resume(cpu_resume),
	.internal_osc_enable(internal_osc_enable),
	.digital_clock_enable(digital_clock_enable),
	.interrupts_enable(interrupts_enable),
	.regulator_enable(regulator_enable),
	.internal_reset(internal_reset),
	.mode_state(mode_state)
);
